// ### clk_mode_pkg.sv
// constants, register map and mode type shared by the clock and mode control files
package clk_mode_pkg;

   // ***************************************************************
   // register map (byte addresses on the apb bus)
   // ***************************************************************
   localparam logic [11:0] OFS_SYS_CLOCK_CTRL = 12'h000;
   localparam logic [11:0] OFS_FAST_OSC_CTRL  = 12'h004;
   localparam logic [11:0] OFS_MODE_STATUS    = 12'h008;

   // sys_clock_ctrl_reg fields
   localparam int          SEL_MSB       = 7;
   localparam int          SEL_LSB       = 5;
   localparam int          FAST_KEEP_BIT = 1;
   localparam int          SLOW_KEEP_BIT = 0;
   localparam logic [2:0]  SEL_RST       = 3'h0;
   localparam logic        KEEP_RST      = 1'b0;

   // fast oscillator control register fields
   localparam int          FAST_EN_BIT   = 0;
   localparam logic        FAST_EN_RST   = 1'b1;

   // mode status register fields
   localparam int          ST_MODE_LSB   = 0;
   localparam int          ST_MODE_MSB   = 2;
   localparam int          ST_CPU_BIT    = 4;
   localparam int          ST_SYS_BIT    = 5;
   localparam int          ST_FAST_BIT   = 6;
   localparam int          ST_SUB_BIT    = 7;
   localparam int          ST_SLOW_BIT   = 8;
   localparam int          ST_ASEL_LSB   = 12;
   localparam int          ST_ASEL_MSB   = 14;

   // ***************************************************************
   // clock selection codes
   // ***************************************************************
   localparam logic [2:0]  SEL_SUB       = 3'h7;
   localparam int          DIV_W         = 6;
   localparam logic [5:0]  DIV_ONE       = 6'h01;

   typedef enum logic [2:0] {
      RUN_FAST,
      RUN_SLOW,
      HALT_SLEEP,
      CPU_OFF_SLOW_OSC_ON,
      CPU_OFF_BOTH_OSC_ON,
      CPU_OFF_FAST_OSC_ON
   } mode_e;

endpackage

// ### clk_div_if.sv
// carrier between the mode controller and the fast clock ratio divider
`timescale 1ns/1ps
interface clk_div_if;
   logic       tick_in;   // gated fast oscillator tick
   logic [2:0] ratio;     // power of two divide code
   logic       restart;   // reload divider when a new selection is adopted
   logic       tick_out;  // divided tick

   modport ctrl (output tick_in, output ratio, output restart, input tick_out);
   modport div  (input tick_in, input ratio, input restart, output tick_out);
endinterface

// ### fast_ratio_div.sv
// divides the fast oscillator tick by 1 to 64 on a power of two code
`timescale 1ns/1ps
module fast_ratio_div #(
   parameter int W = clk_mode_pkg::DIV_W
) (
   input  wire logic clk,     // system clock
   input  wire logic resetn,  // asynchronous reset, active low
   clk_div_if.div    dv       // ticks and ratio from the controller
);

   typedef struct packed {
      logic [W-1:0] count;
   } div_s;

   div_s         s_q;
   div_s         s_d;
   logic [W-1:0] last;

   // period ends on the fast tick that completes 2**ratio input ticks
   assign last        = W'((clk_mode_pkg::DIV_ONE << dv.ratio) - clk_mode_pkg::DIV_ONE);
   assign dv.tick_out = dv.tick_in && (s_q.count == last);

   always_comb begin
      s_d = s_q;
      if (dv.restart) begin
         s_d.count = '0;
      end else if (dv.tick_out) begin
         s_d.count = '0;
      end else if (dv.tick_in) begin
         s_d.count = s_q.count + W'(1);
      end
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

endmodule

// ### system_clock_mode_control.sv
// system clock selection and operating mode control with an apb register port
//
// What this block does
// - fast mode clocks the cpu from fast oscillator divided by 1 to 64.
// - select code 111 gives slow mode clocked from the slow rc sub clock.
// - a time base clock from the slow rc oscillator feeds peripherals.
// - in slow mode the fast oscillator runs or stops by its enable bit.
// - fast mode keeps cpu, fast, sub and slow rc clocks all running.
// - halt with both keep bits low: sleep, only slow rc clock stays on.
// - halt, fast keep low, slow keep high: sub on; system clock only when 111.
// - halt with both keep bits high: every clock stays on, cpu stops.
// - halt, fast keep high, slow keep low: fast on; system clock only below 111.
// - exactly six modes: fast, slow, sleep and three cpu-off idle variants.
// - select field codes fast divided by 1..64 and sub clock; resets to 000.
//
// Local design decisions: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module system_clock_mode_control (
   input  wire logic        clk,             // system clock, 100 mhz
   input  wire logic        resetn,          // asynchronous reset, active low
   input  wire logic        psel,            // apb select
   input  wire logic        penable,         // apb access phase
   input  wire logic        pwrite,          // apb write
   input  wire logic [11:0] paddr,           // apb byte address
   input  wire logic [31:0] pwdata,          // apb write data
   output      logic [31:0] prdata,          // apb read data
   output      logic        pready,          // apb ready
   output      logic        pslverr,         // apb error on unmapped address
   input  wire logic        fast_rc_osc,     // one-cycle tick per fast oscillator period
   input  wire logic        slow_rc_osc,     // one-cycle tick per slow oscillator period
   input  wire logic        halt_req,        // cpu halt, one-cycle pulse
   input  wire logic        wake_req,        // wake from a cpu-off mode, one-cycle pulse
   output      logic        sys_clk_tick,    // cpu clock enable tick
   output      logic        fast_clk_tick,   // fast clock for peripherals
   output      logic        sub_clk_tick,    // sub clock tick
   output      logic        time_base_clock, // time base tick
   output      logic        fast_osc_on,     // fast oscillator enable
   output      logic        slow_osc_on,     // slow rc oscillator enable
   output      logic        sub_clk_on,      // sub clock gate
   output      logic        sys_clk_on,      // system clock gate
   output      logic        cpu_run,         // cpu running
   output      logic [2:0]  mode             // current operating mode
);

   // ***************************************************************
   // state
   // ***************************************************************
   typedef struct packed {
      clk_mode_pkg::mode_e mode;
      logic [2:0]          sel;
      logic                fast_keep;
      logic                slow_keep;
      logic                fast_osc_en;
      logic [2:0]          active_sel;
      logic [31:0]         rdata;
      logic                sys_tick;
      logic                fast_tick;
      logic                sub_tick;
      logic                tb_tick;
   } ctrl_s;

   ctrl_s       s_q;
   ctrl_s       s_d;
   clk_div_if   dv ();

   logic        fast_on;
   logic        sub_on;
   logic        sys_on;
   logic        cpu_on;
   logic        src_tick;
   logic        take_sel;
   logic        setup;
   logic        access;
   logic        mapped;
   logic [31:0] status;
   logic        sel_pending;
   logic [1:0]  keep;
   logic        halt_take;
   logic        wake_take;

   fast_ratio_div #(
      .W (clk_mode_pkg::DIV_W)
   ) u_div (
      .clk    (clk),
      .resetn (resetn),
      .dv     (dv)
   );

   // ***************************************************************
   // clock gating per mode
   // ***************************************************************
   always_comb begin
      fast_on = 1'b0;
      sub_on  = 1'b0;
      sys_on  = 1'b0;
      cpu_on  = 1'b0;
      // every mode spells out all four gates so no mode inherits a stale one
      case (s_q.mode)
         clk_mode_pkg::RUN_FAST: begin
            fast_on = 1'b1;
            sub_on  = 1'b1;
            sys_on  = 1'b1;
            cpu_on  = 1'b1;
         end
         clk_mode_pkg::RUN_SLOW: begin
            fast_on = s_q.fast_osc_en;
            sub_on  = 1'b1;
            sys_on  = 1'b1;
            cpu_on  = 1'b1;
         end
         clk_mode_pkg::CPU_OFF_SLOW_OSC_ON: begin
            fast_on = 1'b0;
            sub_on  = 1'b1;
            sys_on  = (s_q.active_sel == clk_mode_pkg::SEL_SUB);
            cpu_on  = 1'b0;
         end
         clk_mode_pkg::CPU_OFF_BOTH_OSC_ON: begin
            fast_on = 1'b1;
            sub_on  = 1'b1;
            sys_on  = 1'b1;
            cpu_on  = 1'b0;
         end
         clk_mode_pkg::CPU_OFF_FAST_OSC_ON: begin
            fast_on = 1'b1;
            sub_on  = 1'b0;
            sys_on  = (s_q.active_sel != clk_mode_pkg::SEL_SUB);
            cpu_on  = 1'b0;
         end
         clk_mode_pkg::HALT_SLEEP: begin
            fast_on = 1'b0;
            sub_on  = 1'b0;
            sys_on  = 1'b0;
            cpu_on  = 1'b0;
         end
         default: begin
            fast_on = 1'b0;
            sub_on  = 1'b0;
            sys_on  = 1'b0;
            cpu_on  = 1'b0;
         end
      endcase
   end

   // ***************************************************************
   // system clock source and glitch free switch-over
   // ***************************************************************
   assign dv.tick_in = fast_rc_osc && fast_on;
   assign dv.ratio   = s_q.active_sel;
   // the new selection is only adopted where a period has just ended, so the
   // cpu never sees a short period; a stopped system clock switches at once
   assign src_tick   = (s_q.active_sel == clk_mode_pkg::SEL_SUB) ?
                       (slow_rc_osc && sub_on) : dv.tick_out;
   assign sel_pending = (s_q.sel != s_q.active_sel);
   assign take_sel   = (src_tick || !sys_on) && sel_pending;
   assign dv.restart = take_sel;

   // ***************************************************************
   // halt and wake qualification
   // ***************************************************************
   // a halt only means something while the cpu runs and a wake only while it
   // is off, so stray pulses in the other modes are dropped here
   assign keep      = {s_q.fast_keep, s_q.slow_keep};
   assign halt_take = halt_req && cpu_on;
   assign wake_take = wake_req && !cpu_on;

   // ***************************************************************
   // apb decode
   // ***************************************************************
   assign setup   = psel && !penable;
   assign access  = psel && penable;
   assign mapped  = (paddr == clk_mode_pkg::OFS_SYS_CLOCK_CTRL) ||
                    (paddr == clk_mode_pkg::OFS_FAST_OSC_CTRL) ||
                    (paddr == clk_mode_pkg::OFS_MODE_STATUS);
   // zero wait state: every register answers in its access cycle
   assign pready  = 1'b1;
   // writes to the read-only status word are dropped without an error
   assign pslverr = access && !mapped;

   always_comb begin
      status = '0;
      status[clk_mode_pkg::ST_MODE_MSB:clk_mode_pkg::ST_MODE_LSB] = s_q.mode;
      status[clk_mode_pkg::ST_CPU_BIT]  = cpu_on;
      status[clk_mode_pkg::ST_SYS_BIT]  = sys_on;
      status[clk_mode_pkg::ST_FAST_BIT] = fast_on;
      status[clk_mode_pkg::ST_SUB_BIT]  = sub_on;
      status[clk_mode_pkg::ST_SLOW_BIT] = 1'b1;
      status[clk_mode_pkg::ST_ASEL_MSB:clk_mode_pkg::ST_ASEL_LSB] = s_q.active_sel;
   end

   // ***************************************************************
   // next state
   // ***************************************************************
   always_comb begin
      s_d = s_q;

      // read data is captured in the setup cycle so prdata is a flip-flop
      if (setup) begin
         s_d.rdata = '0;
         case (paddr)
            clk_mode_pkg::OFS_SYS_CLOCK_CTRL: begin
               s_d.rdata[clk_mode_pkg::SEL_MSB:clk_mode_pkg::SEL_LSB] = s_q.sel;
               s_d.rdata[clk_mode_pkg::FAST_KEEP_BIT] = s_q.fast_keep;
               s_d.rdata[clk_mode_pkg::SLOW_KEEP_BIT] = s_q.slow_keep;
            end
            clk_mode_pkg::OFS_FAST_OSC_CTRL: begin
               s_d.rdata[clk_mode_pkg::FAST_EN_BIT] = s_q.fast_osc_en;
            end
            clk_mode_pkg::OFS_MODE_STATUS: begin
               s_d.rdata = status;
            end
            default: begin
               s_d.rdata = '0;
            end
         endcase
      end

      if (access && pwrite) begin
         case (paddr)
            clk_mode_pkg::OFS_SYS_CLOCK_CTRL: begin
               s_d.sel       = pwdata[clk_mode_pkg::SEL_MSB:clk_mode_pkg::SEL_LSB];
               s_d.fast_keep = pwdata[clk_mode_pkg::FAST_KEEP_BIT];
               s_d.slow_keep = pwdata[clk_mode_pkg::SLOW_KEEP_BIT];
            end
            clk_mode_pkg::OFS_FAST_OSC_CTRL: begin
               s_d.fast_osc_en = pwdata[clk_mode_pkg::FAST_EN_BIT];
            end
            default: begin
               s_d.sel = s_q.sel;
            end
         endcase
      end

      if (take_sel) begin
         s_d.active_sel = s_q.sel;
      end

      // mode sequencing; running mode always follows the adopted selection
      case (s_q.mode)
         clk_mode_pkg::RUN_FAST,
         clk_mode_pkg::RUN_SLOW: begin
            // keep bits are sampled at the halt itself; later writes wait for the next halt
            if (halt_take) begin
               case (keep)
                  2'h0:    s_d.mode = clk_mode_pkg::HALT_SLEEP;
                  2'h1:    s_d.mode = clk_mode_pkg::CPU_OFF_SLOW_OSC_ON;
                  2'h3:    s_d.mode = clk_mode_pkg::CPU_OFF_BOTH_OSC_ON;
                  default: s_d.mode = clk_mode_pkg::CPU_OFF_FAST_OSC_ON;
               endcase
            end else if (s_d.active_sel == clk_mode_pkg::SEL_SUB) begin
               s_d.mode = clk_mode_pkg::RUN_SLOW;
            end else begin
               s_d.mode = clk_mode_pkg::RUN_FAST;
            end
         end
         clk_mode_pkg::HALT_SLEEP,
         clk_mode_pkg::CPU_OFF_SLOW_OSC_ON,
         clk_mode_pkg::CPU_OFF_BOTH_OSC_ON,
         clk_mode_pkg::CPU_OFF_FAST_OSC_ON: begin
            if (wake_take) begin
               s_d.mode = (s_d.active_sel == clk_mode_pkg::SEL_SUB) ?
                          clk_mode_pkg::RUN_SLOW : clk_mode_pkg::RUN_FAST;
            end
         end
         default: begin
            s_d.mode = clk_mode_pkg::RUN_FAST;
         end
      endcase

      s_d.sys_tick  = src_tick && sys_on;
      s_d.fast_tick = dv.tick_in;
      s_d.sub_tick  = slow_rc_osc && sub_on;
      s_d.tb_tick   = slow_rc_osc;
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         s_q.rdata       <= '0;
         s_q.sys_tick    <= 1'b0;
         s_q.fast_tick   <= 1'b0;
         s_q.sub_tick    <= 1'b0;
         s_q.tb_tick     <= 1'b0;
         s_q.mode        <= clk_mode_pkg::RUN_FAST;
         s_q.sel         <= clk_mode_pkg::SEL_RST;
         s_q.active_sel  <= clk_mode_pkg::SEL_RST;
         s_q.fast_keep   <= clk_mode_pkg::KEEP_RST;
         s_q.slow_keep   <= clk_mode_pkg::KEEP_RST;
         s_q.fast_osc_en <= clk_mode_pkg::FAST_EN_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign prdata          = s_q.rdata;
   assign sys_clk_tick    = s_q.sys_tick;
   assign fast_clk_tick   = s_q.fast_tick;
   assign sub_clk_tick    = s_q.sub_tick;
   assign time_base_clock = s_q.tb_tick;
   assign fast_osc_on     = fast_on;
   // the watchdog is always on, so the slow rc never stops in any mode
   assign slow_osc_on     = 1'b1;
   assign sub_clk_on      = sub_on;
   assign sys_clk_on      = sys_on;
   assign cpu_run         = cpu_on;
   assign mode            = s_q.mode;

endmodule

// ### system_clock_mode_control_asserts.sv
// concurrent checks on the ports of the clock and mode control block
`timescale 1ns/1ps
module system_clock_mode_control_asserts (
   input wire logic       clk,             // clock
   input wire logic       resetn,          // reset, active low
   input wire logic       fast_rc_osc,     // fast tick in
   input wire logic       slow_rc_osc,     // slow tick in
   input wire logic       halt_req,        // halt pulse
   input wire logic       wake_req,        // wake pulse
   input wire logic       sys_clk_tick,    // cpu tick
   input wire logic       fast_clk_tick,   // fast tick out
   input wire logic       sub_clk_tick,    // sub tick out
   input wire logic       time_base_clock, // time base tick
   input wire logic       fast_osc_on,     // fast gate
   input wire logic       slow_osc_on,     // slow gate
   input wire logic       sub_clk_on,      // sub gate
   input wire logic       sys_clk_on,      // system gate
   input wire logic       cpu_run,         // cpu running
   input wire logic [2:0] mode             // operating mode
);
   // ****************************************
   // mode and gate relations
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   sequence s_run_halt;
      halt_req && mode <= 3'h1;
   endsequence
   sequence s_off_wake;
      wake_req && mode >= 3'h2;
   endsequence
   chk_fast_gates: assert property (mode == 3'h0 |-> cpu_run && sys_clk_on && fast_osc_on && sub_clk_on)
      else $error("fast mode gate wrong");
   chk_slow_gates: assert property (mode == 3'h1 |-> cpu_run && sys_clk_on && sub_clk_on)
      else $error("slow mode gate wrong");
   chk_sleep_gates: assert property (mode == 3'h2 |-> !(cpu_run | sys_clk_on | fast_osc_on | sub_clk_on) && slow_osc_on)
      else $error("sleep gate wrong");
   chk_idle_sub: assert property (mode == 3'h3 |-> !cpu_run && !fast_osc_on && sub_clk_on)
      else $error("slow keep idle gate wrong");
   chk_idle_both: assert property (mode == 3'h4 |-> !cpu_run && sys_clk_on && fast_osc_on && sub_clk_on)
      else $error("both keep idle gate wrong");
   chk_idle_fast: assert property (mode == 3'h5 |-> !cpu_run && fast_osc_on && !sub_clk_on)
      else $error("fast keep idle gate wrong");
   chk_mode_range: assert property (mode <= 3'h5)
      else $error("mode out of range");
   chk_halt_enter: assert property (s_run_halt |=> !cpu_run && mode >= 3'h2)
      else $error("halt not taken");
   chk_wake_leave: assert property (s_off_wake |=> cpu_run && mode <= 3'h1)
      else $error("wake not taken");
   chk_time_base: assert property (slow_rc_osc |=> time_base_clock)
      else $error("time base tick missing");
   chk_fast_stop: assert property (fast_rc_osc && !fast_osc_on |=> !fast_clk_tick)
      else $error("fast tick while stopped");
   // a tick that lands on a mode change may legitimately go either way
   chk_sub_sys: assert property (mode == 3'h1 && slow_rc_osc && !halt_req |=> sys_clk_tick || mode != 3'h1)
      else $error("slow mode cpu tick missing");
   chk_sub_tick: assert property (slow_rc_osc && sub_clk_on |=> sub_clk_tick)
      else $error("sub tick missing");
   chk_sub_gate: assert property (slow_rc_osc && !sub_clk_on |=> !sub_clk_tick)
      else $error("sub tick while gated");
   chk_fast_tick: assert property (fast_rc_osc && fast_osc_on |=> fast_clk_tick)
      else $error("fast tick missing");
endmodule

bind system_clock_mode_control system_clock_mode_control_asserts u_chk (.clk, .resetn, .fast_rc_osc, .slow_rc_osc,
   .halt_req, .wake_req, .sys_clk_tick, .fast_clk_tick, .sub_clk_tick, .time_base_clock, .fast_osc_on, .slow_osc_on,
   .sub_clk_on,
   .sys_clk_on, .cpu_run, .mode);

// ### system_clock_mode_control_test.sv
// self-checking bench for the system clock and mode control block
`timescale 1ns/1ps
module system_clock_mode_control_test;
   logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        fast_rc_osc = 1'b0, slow_rc_osc = 1'b0, halt_req = 1'b0, wake_req = 1'b0;
   logic        want = 1'b0, div_on = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, rnd = 32'h0001864E;
   logic [31:0] expq[$];
   logic        pready, pslverr, sys_clk_tick, fast_clk_tick, sub_clk_tick, time_base_clock;
   logic        fast_osc_on, slow_osc_on, sub_clk_on, sys_clk_on, cpu_run;
   logic [2:0]  mode;
   logic [2:0]  idle_m[4] = '{3'h2, 3'h3, 3'h5, 3'h4};
   int          n_mismatch = 0, checks = 0, cycles = 0, cnt = 0, nsys = 0, div_n = 0, slow_cnt = 0;

   system_clock_mode_control dut (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
      .pslverr, .fast_rc_osc, .slow_rc_osc, .halt_req, .wake_req, .sys_clk_tick, .fast_clk_tick, .sub_clk_tick,
      .time_base_clock, .fast_osc_on, .slow_osc_on, .sub_clk_on, .sys_clk_on, .cpu_run, .mode);

   always #5 clk = ~clk;

   // ****************************************
   // helpers
   // ****************************************
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // gate bits {slow, sub, fast, sys, cpu} as the mode table lays them out
   function automatic logic [31:0] st_exp(input logic [2:0] m, input logic [2:0] a, input logic fe);
      logic [4:0] g;
      case (m)
         3'h0: g = 5'h1F;
         3'h1: g = {2'h3, fe, 2'h3};
         3'h2: g = 5'h10;
         3'h3: g = {2'h3, 1'b0, a == 3'h7, 1'b0};
         3'h4: g = 5'h1E;
         default: g = {2'h2, 1'b1, a != 3'h7, 1'b0};
      endcase
      return {17'h0, a, 3'h0, g, 1'b0, m};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic test_done;
      $display("checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic chk,
                      input logic [31:0] e);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      want <= chk;
      if (chk) expq.push_back(e);
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      want <= 1'b0;
   endtask

   // the adopted selection only moves at a source tick while the system clock runs, so poll it
   task automatic wait_sel(input logic [2:0] s);
      do apb(1'b0, 12'h008, 32'h0, 1'b0, 32'h0); while (rd[14:12] !== s);
   endtask

   task automatic pulse(input logic h);
      @(posedge clk);
      if (h) halt_req <= 1'b1;
      else wake_req <= 1'b1;
      @(posedge clk);
      halt_req <= 1'b0;
      wake_req <= 1'b0;
   endtask

   // ****************************************
   // stimulus, monitor and timeout
   // ****************************************
   always @(posedge clk) begin
      rnd <= xs(rnd);
      fast_rc_osc <= rnd[0];
      slow_cnt <= (slow_cnt == 36) ? 0 : slow_cnt + 1;
      slow_rc_osc <= (slow_cnt == 36);
      cycles++;
      if (cycles > 40000) begin
         n_mismatch++;
         test_done();
      end
   end

   always @(posedge clk) begin
      if (psel && penable && pready && want) check(prdata, expq.pop_front());
      if (psel && penable && pready) check({31'h0, pslverr}, {31'h0, !(paddr inside {12'h000, 12'h004, 12'h008})});
      if (sys_clk_tick === 1'b1) begin
         // only periods ending once div_on is set are checked, so the first ones after the switch can be missed
         if (div_on) check(cnt + fast_clk_tick, 32'h1 << div_n);
         nsys++;
         cnt = 0;
      end else if (fast_clk_tick === 1'b1) cnt++;
   end

   initial begin
      logic [2:0]  sel;
      logic [2:0]  m;
      logic [31:0] w;
      repeat (12) @(posedge clk);
      resetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0, 1'b1, 32'h0);
      apb(1'b0, 12'h004, 32'h0, 1'b1, 32'h1);
      apb(1'b0, 12'h008, 32'h0, 1'b1, st_exp(3'h0, 3'h0, 1'b1));
      apb(1'b0, 12'h00C, 32'h0, 1'b1, 32'h0);
      w = rnd;
      apb(1'b1, 12'h000, w, 1'b0, 32'h0);
      apb(1'b0, 12'h000, 32'h0, 1'b1, w & 32'h000000E3);
      for (int k = 0; k < 4; k++) begin
         for (int s = 0; s < 2; s++) begin
            sel = s ? 3'h7 : 3'h0;
            m = s ? 3'h1 : 3'h0;
            apb(1'b1, 12'h000, {24'h0, sel, 3'h0, k[1:0]}, 1'b0, 32'h0);
            wait_sel(sel);
            apb(1'b0, 12'h008, 32'h0, 1'b1, st_exp(m, sel, 1'b1));
            pulse(1'b1);
            pulse(1'b1);
            apb(1'b0, 12'h008, 32'h0, 1'b1, st_exp(idle_m[k], sel, 1'b1));
            pulse(1'b0);
            pulse(1'b0);
            apb(1'b0, 12'h008, 32'h0, 1'b1, st_exp(m, sel, 1'b1));
         end
      end
      apb(1'b1, 12'h004, 32'h0, 1'b0, 32'h0);
      apb(1'b0, 12'h008, 32'h0, 1'b1, st_exp(3'h1, 3'h7, 1'b0));
      apb(1'b1, 12'h004, 32'h1, 1'b0, 32'h0);
      for (int n = 0; n < 7; n++) begin
         apb(1'b1, 12'h000, n << 5, 1'b0, 32'h0);
         wait_sel(n[2:0]);
         div_n = n;
         nsys = 0;
         div_on = 1'b1;
         while (nsys < 5) @(posedge clk);
         div_on = 1'b0;
      end
      test_done();
   end
endmodule
